//--- hdl/rsa_rail_strobe_regs.sv
`timescale 1ns/1ns

// Function
// - The third buck converter's strobe field is bits 6:4, 000b is unsequenced, 001b-110b mean strobes 1-6.
// - The first linear regulator's field is bits 3:0, 0000b is unsequenced, 0001b-0111b mean strobes 1-7.
// - In four-bit regulator fields, codes 1000b and 1001b leave the rail unsequenced.
// - A four-bit regulator field of 1110b enables the rail at strobe fourteen.
// - A four-bit regulator field of 1111b enables the rail at strobe fifteen once the system supply is up.
// - The second linear regulator's field is bits 7:4 of register b with the same four-bit coding.
// - The first load switch field is bits 2:0 of register b, 000b is unsequenced, 001b-100b mean strobes 1-4.
// - Three-bit code 111b is taken as strobe seven, the upper codes mapping straight to strobe n.
// - Bit 7 of register a and bit 3 of register b are read-only and read as zero.
// - Writes to the strobe registers land only while the password mechanism permits them.
// - Register c sits at address 0x1C and resets to 0x40.
// - Registers a and b reset to values that depend on the product variant.
module rsa_rail_strobe_regs #(
    parameter int VARIANT = 0
) (
    input wire logic clk,
    input wire logic rst,
    input wire rsa_pkg::rsa_req_type req,
    input wire logic wr_permit,
    input wire rsa_pkg::rsa_seq_type seq,
    input wire logic [rsa_pkg::RAIL_COUNT-1:0] direct_en,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [3:0] strobe_reached,
    output logic [rsa_pkg::RAIL_COUNT-1:0] rail_en
);
    import rsa_pkg::*;

    rsa_state_type state_reg;
    rsa_state_type state_next;

    // ------------------------------------------------------------
    // code decoding
    // ------------------------------------------------------------

    // three-bit fields: 0 is unsequenced, n is strobe n
    // top code as strobe seven
    function automatic logic [3:0] target3(input logic [2:0] code);
        target3 = {1'b0, code};
    endfunction

    // four-bit fields: 8, 9 and the reserved codes give no target
    // codes 8 and 9
    function automatic logic [3:0] target4(input logic [3:0] code);
        if (code <= CODE_LAST_PLAIN) begin
            target4 = code;
        end else if (code == CODE_STROBE14 || code == CODE_STROBE15) begin
            target4 = code;
        end else begin
            target4 = CODE_NONE;
        end
    endfunction

    // mapped read value; unmapped addresses read zero
    function automatic logic [7:0] read_value(input rsa_state_type s, input logic [7:0] addr);
        case (addr)
            ADDR_SELECT_A: read_value = s.select_a;
            ADDR_SELECT_B: read_value = s.select_b;
            ADDR_SELECT_C: read_value = s.select_c;
            default: read_value = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // per-rail targets
    // ------------------------------------------------------------
    logic [3:0] target [RAIL_COUNT];

    assign target[RAIL_BUCK3] = target3(state_reg.select_a[BUCK3_LSB +: 3]);
    assign target[RAIL_LREG1] = target4(state_reg.select_a[LREG1_LSB +: 4]);
    assign target[RAIL_LREG2] = target4(state_reg.select_b[LREG2_LSB +: 4]);
    assign target[RAIL_SW1] = target3(state_reg.select_b[SW1_LSB +: 3]);
    assign target[RAIL_SW2] = target3(state_reg.select_c[SW2_LSB +: 3]);

    // ------------------------------------------------------------
    // rail enable decision
    // ------------------------------------------------------------
    logic [RAIL_COUNT-1:0] rail_want;

    genvar gi;
    generate
        for (gi = 0; gi < RAIL_COUNT; gi++) begin : g_rail
            logic reached_ok;
            // strobe fourteen compares like any other count
            // strobe fifteen also waits for the system supply
            assign reached_ok = (state_reg.reached >= target[gi]) &&
                ((target[gi] != STROBE_WITH_SYS) || seq.sys_ok);
            // sequenced rails follow the count, others the direct bit
            assign rail_want[gi] = (target[gi] == CODE_NONE) ? direct_en[gi] : reached_ok;
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        if (req.wr && wr_permit) begin
            // reserved codes are stored but sequence nothing
            case (req.addr)
                ADDR_SELECT_A: state_next.select_a = req.wdata & MASK_SELECT_A;
                ADDR_SELECT_B: state_next.select_b = req.wdata & MASK_SELECT_B;
                ADDR_SELECT_C: state_next.select_c = req.wdata & MASK_SELECT_C;
                default: state_next.select_a = state_reg.select_a;
            endcase
        end
        // a read returns the value held before any same-cycle write
        if (req.rd) begin
            state_next.rdata = read_value(state_reg, req.addr);
            state_next.rvalid = 1'b1;
        end
        // clear wins over a strobe so power-down restarts from zero
        if (seq.clear) begin
            state_next.reached = 4'h0;
        end else if (seq.strobe) begin
            state_next.reached = seq.index;
        end
        state_next.rail_en = rail_want;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.select_a <= RST_SELECT_A[VARIANT];
            state_reg.select_b <= RST_SELECT_B[VARIANT];
            state_reg.select_c <= RST_SELECT_C;
            state_reg.rdata <= 8'h00;
            state_reg.rvalid <= 1'b0;
            state_reg.reached <= 4'h0;
            state_reg.rail_en <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata = state_reg.rdata;
    assign rvalid = state_reg.rvalid;
    assign strobe_reached = state_reg.reached;
    assign rail_en = state_reg.rail_en;

endmodule

//--- hdl/rsa_pkg.sv
package rsa_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SELECT_A = 8'h1A;
    localparam logic [7:0] ADDR_SELECT_B = 8'h1B;
    localparam logic [7:0] ADDR_SELECT_C = 8'h1C;

    // writable bits; reserved bits stay zero
    localparam logic [7:0] MASK_SELECT_A = 8'h7F;
    localparam logic [7:0] MASK_SELECT_B = 8'hF7;
    localparam logic [7:0] MASK_SELECT_C = 8'h70;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BUCK3_LSB = 4;
    localparam int LREG1_LSB = 0;
    localparam int LREG2_LSB = 4;
    localparam int SW1_LSB = 0;
    localparam int SW2_LSB = 4;

    // ------------------------------------------------------------
    // reset values per product variant 0..3 for registers a and b; register c has one value for all
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SELECT_A [4] = '{8'h3B, 8'h5F, 8'h5F, 8'h5F};
    localparam logic [7:0] RST_SELECT_B [4] = '{8'h21, 8'h23, 8'h32, 8'h32};
    localparam logic [7:0] RST_SELECT_C = 8'h40;

    // ------------------------------------------------------------
    // strobe codes
    // ------------------------------------------------------------
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_LAST_PLAIN = 4'h7;
    localparam logic [3:0] CODE_STROBE14 = 4'hE;
    localparam logic [3:0] CODE_STROBE15 = 4'hF;
    localparam logic [3:0] STROBE_WITH_SYS = 4'hF;

    // rail index order on rail_en
    localparam int RAIL_COUNT = 5;
    localparam int RAIL_BUCK3 = 0;
    localparam int RAIL_LREG1 = 1;
    localparam int RAIL_LREG2 = 2;
    localparam int RAIL_SW1 = 3;
    localparam int RAIL_SW2 = 4;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsa_req_type;

    typedef struct packed {
        logic strobe;
        logic [3:0] index;
        logic clear;
        logic sys_ok;
    } rsa_seq_type;

    typedef struct packed {
        logic [7:0] select_a;
        logic [7:0] select_b;
        logic [7:0] select_c;
        logic [7:0] rdata;
        logic rvalid;
        logic [3:0] reached;
        logic [RAIL_COUNT-1:0] rail_en;
    } rsa_state_type;

endpackage

//--- tb/rsa_rail_strobe_asserts.sv
`timescale 1ns/1ns
// port-level checks of the register and strobe ports
module rsa_rail_strobe_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire rsa_pkg::rsa_req_type req,
    input wire rsa_pkg::rsa_seq_type seq,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire logic [3:0] strobe_reached
);
    import rsa_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // read answers and reserved bits; rdata must not drift between reads
    AST_RD_ANS: assert property (req.rd |=> rvalid) else $error("read lost");
    AST_RD_ONE: assert property (!req.rd |=> !rvalid) else $error("stray rvalid");
    AST_RD_HOLD: assert property (!req.rd |=> $stable(rdata)) else $error("rdata moved");
    AST_RES_A: assert property (req.rd && req.addr == 8'h1A |=> !rdata[7]) else $error("a7");
    AST_RES_B: assert property (req.rd && req.addr == 8'h1B |=> !rdata[3]) else $error("b3");
    AST_UNMAP: assert property (req.rd && req.addr > 8'h1C |=> rdata == 8'h00) else $error("map");
    // strobe count: clear wins, a strobe loads its index, otherwise it holds
    AST_CLR: assert property (seq.clear |=> strobe_reached == 4'h0) else $error("clear");
    AST_STB: assert property (seq.strobe && !seq.clear |=> strobe_reached == $past(seq.index))
        else $error("strobe");
    AST_HOLD: assert property (!seq.strobe && !seq.clear |=> $stable(strobe_reached))
        else $error("count moved");
    cover property (req.wr && req.addr == 8'h1C);
    cover property (seq.strobe && seq.index == 4'hF && seq.sys_ok);
    cover property (seq.clear);
endmodule
bind rsa_rail_strobe_regs rsa_rail_strobe_asserts i_chk (.clk(clk), .rst(rst), .req(req),
    .seq(seq), .rdata(rdata), .rvalid(rvalid), .strobe_reached(strobe_reached));

//--- tb/rsa_host.sv
`timescale 1ns/1ns
// host model; released lines carry the inverse of the last value, not a stale copy
module rsa_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output rsa_pkg::rsa_req_type req,
    output logic wr_permit
);
    import rsa_pkg::*;
    initial req = '0;
    initial wr_permit = 1'b0;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic p,
                        output logic [7:0] q);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        wr_permit <= p;
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        wr_permit <= !p;
        #1;
        for (int n = 0; n < 4 && !w && rvalid !== 1'b1; n++) @(posedge clk);
        q = rvalid ? rdata : 8'hXX;
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    import rsa_pkg::*;
    logic clk, rst, wr_permit, rvalid;
    rsa_req_type req;
    rsa_seq_type seq;
    logic [4:0] direct_en, rail_en;
    logic [7:0] rdata, q;
    logic [3:0] strobe_reached;
    logic [7:0] img [6] = '{8'h5F, 8'h23, 8'h40, 8'h7F, 8'hF7, 8'h70};
    // second part on the same bus, variant 0, to cover the variant 0 reset image too
    logic [7:0] rdata_v0;
    logic [4:0] rail_en_v0;
    logic [7:0] img_v0 [3] = '{8'h3B, 8'h21, 8'h40};
    int n_fail = 0;
    int tests_run = 0;
    rsa_rail_strobe_regs #(.VARIANT(1)) i_dut (.clk(clk), .rst(rst), .req(req),
        .wr_permit(wr_permit), .seq(seq), .direct_en(direct_en), .rdata(rdata),
        .rvalid(rvalid), .strobe_reached(strobe_reached), .rail_en(rail_en));
    rsa_rail_strobe_regs #(.VARIANT(0)) i_dut_v0 (.clk(clk), .rst(rst), .req(req),
        .wr_permit(wr_permit), .seq(seq), .direct_en(direct_en), .rdata(rdata_v0),
        .rvalid(), .strobe_reached(), .rail_en(rail_en_v0));
    rsa_host i_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req),
        .wr_permit(wr_permit));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // expected enable of one rail; w marks the four-bit coding
    function automatic logic want(logic [3:0] c, logic w, logic [3:0] k, logic s, logic d);
        if (c == 4'h0 || (w && c inside {4'h8, 4'h9})) return d;
        if (w && c == 4'hE) return k >= 4'hE;
        if (w && c == 4'hF) return k == 4'hF && s;
        return k >= c;
    endfunction
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // strobe k (0 = clear), then compare count and enables once the two-cycle lag is over
    task automatic step(input logic [3:0] k, input logic s, input logic [2:0] b, input logic [3:0] l);
        logic [4:0] d, e;
        d = 5'(k * 4'h5) ^ {5{s}};
        @(posedge clk);
        seq <= '{strobe: k != 0, index: k, clear: k == 0, sys_ok: s};
        direct_en <= d;
        @(posedge clk);
        seq.strobe <= 1'b0;
        seq.clear <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        e = {want({1'b0, b}, 0, k, s, d[4]), want({1'b0, ~b}, 0, k, s, d[3]),
             want(l, 1, k, s, d[2]), want(l, 1, k, s, d[1]), want({1'b0, b}, 0, k, s, d[0])};
        chk({strobe_reached, rail_en}, {k, e});
    endtask
    initial begin
        rst = 1'b1;
        seq = '0;
        direct_en = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            i_host.xfer(0, 8'h1A + 8'(i), 8'h00, 0, q);
            chk({1'b0, q}, {1'b0, img[i]});
            chk({1'b0, rdata_v0}, {1'b0, img_v0[i]});
            i_host.xfer(1, 8'h1A + 8'(i), 8'hFF, 0, q);
            i_host.xfer(0, 8'h1A + 8'(i), 8'h00, 0, q);
            chk({1'b0, q}, {1'b0, img[i]});
            i_host.xfer(1, 8'h1A + 8'(i), 8'hFF, 1, q);
            i_host.xfer(0, 8'h1A + 8'(i), 8'h00, 0, q);
            chk({1'b0, q}, {1'b0, img[i + 3]});
        end
        i_host.xfer(0, 8'h1D, 8'h00, 0, q);
        chk({1'b0, q}, 9'h000);
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 16; c++) begin
                if (c inside {[10:13]}) continue;
                i_host.xfer(1, 8'h1A, {1'b0, 3'(c), 4'(c)}, 1, q);
                i_host.xfer(1, 8'h1B, {4'(c), 1'b0, ~3'(c)}, 1, q);
                i_host.xfer(1, 8'h1C, {1'b0, 3'(c), 4'h0}, 1, q);
                for (int k = 0; k < 16; k++) step(4'(k), 1'(s), 3'(c), 4'(c));
            end
        end
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule
